//--- hdl/acl_map.vh
`ifndef ACL_MAP_VH
`define ACL_MAP_VH

// Register offsets on the serial control bus
`define ACL_AUDIO_CONFIG_ADDR 8'h55
`define ACL_LINK_STATUS_ADDR 8'h5a

// Audio configuration field positions
`define ACL_CFG_TDM_CONV_BIT 7
`define ACL_CFG_AUDIO_OUT_BIT 6
`define ACL_CFG_RST_TYPE_BIT 3
`define ACL_CFG_RST_AIF_BIT 2
`define ACL_CFG_RST_AVI_BIT 1
`define ACL_CFG_RST_ACR_BIT 0

// Writable bits of the configuration register, reserved 5:4 held at zero
`define ACL_CFG_WR_MASK 8'hcf
// Configuration reset value
`define ACL_CFG_RESET 8'h0c

// Status field positions
`define ACL_STS_LINK_RDY_BIT 7
`define ACL_STS_TX_BIT 6
`define ACL_STS_PORT_HI 5
`define ACL_STS_PORT_LO 4
`define ACL_STS_VALID_BIT 3
`define ACL_STS_PLL_BIT 2
`define ACL_STS_NOCLK_BIT 1
`define ACL_STS_STABLE_BIT 0

// Audio source selection value for video-input audio
`define ACL_SRC_VIDEO 1'b0

// Synchroniser depth
`define ACL_SYNC_STAGES 2

`endif

//--- hdl/acl_change_det.v
`timescale 1ns/1ps
`default_nettype none

// Compares each new sample with the previous one, pulses on a difference
module acl_change_det #(
  parameter WIDTH = 8
) (
  input wire mclk,
  input wire rst_n,
  input wire sample_vld,
  input wire [WIDTH-1:0] sample,
  input wire enable,
  output reg changed_r
);

  reg [WIDTH-1:0] prev_r; // Last value seen
  reg seen_r; // A first value has been stored

  // Store each sample; first sample only primes the store
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      prev_r <= {WIDTH{1'b0}};
      seen_r <= 1'b0;
      changed_r <= 1'b0;
    end else begin
      changed_r <= 1'b0;
      if (sample_vld) begin
        prev_r <= sample;
        seen_r <= 1'b1;
        // One-cycle pulse on a difference when enabled
        if (seen_r && enable && (sample != prev_r)) begin
          changed_r <= 1'b1;
        end
      end
    end
  end

endmodule

`default_nettype wire

//--- hdl/acl_regs.v
`timescale 1ns/1ps
`default_nettype none
`include "acl_map.vh"

// What this block does
// - Bit 7 enables TDM conversion and clock
// - Bit 6 drives extracted audio on pins
// - Audio output ignored unless source is 0
// - Bit 3 resets FIFO on type change
// - Bit 2 resets FIFO on audio-frame sum
// - Bit 1 resets FIFO on video-frame sum
// - Bit 0 resets FIFO on N/CTS change
// - Status 7 shows downstream link ready
// - Status 6 transmit active, locked, valid, moded
// - Status 5:4 port mode while transmitting
// - Status 3 shows valid input data
// - Status 2 shows input PLL lock
// - Status 1 shows no input clock
// - Status 0 shows stable input frequency
// - Source select: 0 video, 1 pins
module acl_regs #(
  parameter TYPE_W = 4,
  parameter SUM_W = 8,
  parameter NCTS_W = 40
) (
  input wire mclk,
  input wire rst_n,
  // Serial control bus register port
  input wire [7:0] reg_addr,
  input wire reg_wr,
  input wire [7:0] reg_wdata,
  input wire reg_rd,
  output reg [7:0] reg_rdata_r,
  // Audio source selection from bridge configuration
  input wire audio_mode,
  // Audio samples in both candidate sources
  input wire video_audio_sd,
  input wire pin_audio_sd,
  input wire tdm_conv_clk,
  input wire base_audio_clk,
  output reg downstream_audio_sd_r,
  output wire downstream_audio_clk,
  output reg tdm_conv_en_r,
  output reg serial_audio_out_en_r,
  output reg serial_audio_sd_r,
  // Received packet fields from the audio extractor
  input wire type_vld,
  input wire [TYPE_W-1:0] audio_type,
  input wire aif_vld,
  input wire [SUM_W-1:0] aif_sum,
  input wire avi_vld,
  input wire [SUM_W-1:0] avi_sum,
  input wire acr_vld,
  input wire [NCTS_W-1:0] acr_ncts,
  output reg audio_fifo_rst_r,
  // Live conditions from analog and link logic
  input wire downstream_link_ready,
  input wire serial_tx_active,
  input wire remote_rx_locked,
  input wire link_mode_entered,
  input wire [1:0] serial_port_mode,
  input wire input_data_valid,
  input wire input_pll_lock,
  input wire no_input_clock,
  input wire input_a
);

  // Reset release through two flops
  reg [1:0] rst_sync_r;
  wire srst_n;

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rst_sync_r <= 2'b00;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end
  assign srst_n = rst_sync_r[1];

  // Live status bundle from outside the clock domain
  localparam STS_IN_W = 10;
  wire [STS_IN_W-1:0] sts_raw;
  reg [STS_IN_W-1:0] sts_meta_r; // First stage, read only by second
  reg [STS_IN_W-1:0] sts_sync_r; // Second stage, safe to use

  assign sts_raw = {downstream_link_ready, serial_tx_active,
    remote_rx_locked, link_mode_entered, serial_port_mode,
    input_data_valid, input_pll_lock, no_input_clock, input_a};

  // Two-flop synchroniser
  always @(posedge mclk or negedge srst_n) begin
    if (!srst_n) begin
      sts_meta_r <= {STS_IN_W{1'b0}};
      sts_sync_r <= {STS_IN_W{1'b0}};
    end else begin
      sts_meta_r <= sts_raw;
      sts_sync_r <= sts_meta_r;
    end
  end

  // Synchronised names
  wire s_link_rdy = sts_sync_r[9];
  wire s_tx_active = sts_sync_r[8];
  wire s_rx_locked = sts_sync_r[7];
  wire s_mode_in = sts_sync_r[6];
  wire [1:0] s_port = sts_sync_r[5:4];
  wire s_valid = sts_sync_r[3];
  wire s_pll = sts_sync_r[2];
  wire s_noclk = sts_sync_r[1];
  wire s_stable = sts_sync_r[0];

  // Configuration register
  reg [7:0] cfg_r;
  wire cfg_hit;
  wire sts_hit;

  // Address decode, used for reads and writes
  function hit;
    input [7:0] addr;
    input [7:0] target;
    begin
      hit = (addr == target);
    end
  endfunction

  assign cfg_hit = hit(reg_addr, `ACL_AUDIO_CONFIG_ADDR);
  assign sts_hit = hit(reg_addr, `ACL_LINK_STATUS_ADDR);

  // Config write; reserved bits masked, status writes dropped
  always @(posedge mclk or negedge srst_n) begin
    if (!srst_n) begin
      cfg_r <= `ACL_CFG_RESET;
    end else if (reg_wr && cfg_hit) begin
      cfg_r <= reg_wdata & `ACL_CFG_WR_MASK;
    end
  end

  // Transmit status needs activity, lock, valid input and mode
  wire tx_status;
  assign tx_status = s_tx_active & s_rx_locked & s_valid & s_mode_in;

  // Assembled live status byte
  reg [7:0] status_now;
  always @* begin
    status_now = 8'h00;
    status_now[`ACL_STS_LINK_RDY_BIT] = s_link_rdy;
    status_now[`ACL_STS_TX_BIT] = tx_status;
    // Port mode only meaningful while transmitting
    if (tx_status) begin
      status_now[`ACL_STS_PORT_HI:`ACL_STS_PORT_LO] = s_port;
    end
    status_now[`ACL_STS_VALID_BIT] = s_valid;
    status_now[`ACL_STS_PLL_BIT] = s_pll;
    status_now[`ACL_STS_NOCLK_BIT] = s_noclk;
    status_now[`ACL_STS_STABLE_BIT] = s_stable;
  end

  // Read data, one cycle after the read strobe
  always @(posedge mclk or negedge srst_n) begin
    if (!srst_n) begin
      reg_rdata_r <= 8'h00;
    end else if (reg_rd) begin
      if (cfg_hit) begin
        reg_rdata_r <= cfg_r;
      end else if (sts_hit) begin
        reg_rdata_r <= status_now;
      end else begin
        reg_rdata_r <= 8'h00; // Unmapped reads zero
      end
    end
  end

  // Change detectors for the four FIFO reset triggers
  wire chg_type;
  wire chg_aif;
  wire chg_avi;
  wire chg_acr;

  acl_change_det #(.WIDTH(TYPE_W)) u_det_type (
    .mclk(mclk),
    .rst_n(srst_n),
    .sample_vld(type_vld),
    .sample(audio_type),
    .enable(cfg_r[`ACL_CFG_RST_TYPE_BIT]),
    .changed_r(chg_type)
  );

  acl_change_det #(.WIDTH(SUM_W)) u_det_aif (
    .mclk(mclk),
    .rst_n(srst_n),
    .sample_vld(aif_vld),
    .sample(aif_sum),
    .enable(cfg_r[`ACL_CFG_RST_AIF_BIT]),
    .changed_r(chg_aif)
  );

  acl_change_det #(.WIDTH(SUM_W)) u_det_avi (
    .mclk(mclk),
    .rst_n(srst_n),
    .sample_vld(avi_vld),
    .sample(avi_sum),
    .enable(cfg_r[`ACL_CFG_RST_AVI_BIT]),
    .changed_r(chg_avi)
  );

  acl_change_det #(.WIDTH(NCTS_W)) u_det_acr (
    .mclk(mclk),
    .rst_n(srst_n),
    .sample_vld(acr_vld),
    .sample(acr_ncts),
    .enable(cfg_r[`ACL_CFG_RST_ACR_BIT]),
    .changed_r(chg_acr)
  );

  // Audio path controls and FIFO reset pulse
  wire src_video;
  assign src_video = (audio_mode == `ACL_SRC_VIDEO);

  always @(posedge mclk or negedge srst_n) begin
    if (!srst_n) begin
      audio_fifo_rst_r <= 1'b0;
      tdm_conv_en_r <= 1'b0;
      serial_audio_out_en_r <= 1'b0;
      serial_audio_sd_r <= 1'b0;
      downstream_audio_sd_r <= 1'b0;
    end else begin
      // Any enabled trigger gives a one-cycle reset
      audio_fifo_rst_r <= chg_type | chg_aif | chg_avi | chg_acr;
      tdm_conv_en_r <= cfg_r[`ACL_CFG_TDM_CONV_BIT];
      // Output enable honoured only for video-input audio
      serial_audio_out_en_r <= cfg_r[`ACL_CFG_AUDIO_OUT_BIT] & src_video;
      // Extracted audio to the serial audio pins
      serial_audio_sd_r <= cfg_r[`ACL_CFG_AUDIO_OUT_BIT] & src_video &
        video_audio_sd;
      // Downstream audio source select
      downstream_audio_sd_r <= src_video ? video_audio_sd : pin_audio_sd;
    end
  end

  // Converter clock carries downstream audio when enabled
  assign downstream_audio_clk = tdm_conv_en_r ? tdm_conv_clk :
    base_audio_clk;

endmodule

`default_nettype wire

//--- tb/acl_regs_properties.sv
`timescale 1ns/1ps
`default_nettype none
module acl_regs_props (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata_r,
  input wire logic audio_mode,
  input wire logic video_audio_sd,
  input wire logic pin_audio_sd,
  input wire logic tdm_conv_clk,
  input wire logic base_audio_clk,
  input wire logic downstream_audio_sd_r,
  input wire logic downstream_audio_clk,
  input wire logic tdm_conv_en_r,
  input wire logic serial_audio_out_en_r,
  input wire logic serial_audio_sd_r,
  input wire logic type_vld,
  input wire logic aif_vld,
  input wire logic avi_vld,
  input wire logic acr_vld,
  input wire logic audio_fifo_rst_r,
  input wire logic input_pll_lock,
  input wire logic no_input_clock
);
  // Edges since release; checks wait out the internal reset
  logic [2:0] up_r;
  // Status pin history, so only settled reads are judged
  logic [1:0] s1_r, s2_r, s3_r;
  wire logic st_ok;
  // Release counter
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      up_r <= 3'h0;
    end else if (up_r != 3'h5) begin
      up_r <= up_r + 3'h1;
    end
  end
  // Pin history shift
  always_ff @(posedge mclk) begin
    s1_r <= {input_pll_lock, no_input_clock};
    s2_r <= s1_r;
    s3_r <= s2_r;
  end
  assign st_ok = {input_pll_lock, no_input_clock} == s1_r &&
    s1_r == s2_r && s2_r == s3_r;
  default clocking @(posedge mclk); endclocking
  default disable iff (up_r != 3'h5);
  AST_TDM: assert property (reg_wr && reg_addr == 8'h55
    |-> ##2 tdm_conv_en_r == $past(reg_wdata[7], 2))
    else $error("tdm enable wrong");
  AST_CLK: assert property (downstream_audio_clk ==
    (tdm_conv_en_r ? tdm_conv_clk : base_audio_clk))
    else $error("audio clock mux wrong");
  AST_OEN: assert property (serial_audio_out_en_r
    |-> !$past(audio_mode)) else $error("output enable wrong");
  AST_SSD: assert property (serial_audio_sd_r
    |-> $past(video_audio_sd)) else $error("serial audio wrong");
  AST_SRC: assert property (downstream_audio_sd_r ==
    ($past(audio_mode) ? $past(pin_audio_sd) : $past(video_audio_sd)))
    else $error("source mux wrong");
  AST_FIFO: assert property (audio_fifo_rst_r |->
    $past(type_vld, 2) || $past(aif_vld, 2) ||
    $past(avi_vld, 2) || $past(acr_vld, 2)) else $error("stray reset");
  AST_LIVE: assert property (reg_rd && reg_addr == 8'h5a
    && st_ok |=> reg_rdata_r[2:1] == s1_r) else $error("status stale");
  AST_PORT: assert property (reg_rd && reg_addr == 8'h5a
    |=> reg_rdata_r[6] || reg_rdata_r[5:4] == 2'h0)
    else $error("port mode shown idle");
  AST_RSV: assert property (reg_rd && reg_addr == 8'h55
    |=> reg_rdata_r[5:4] == 2'h0) else $error("reserved bits set");
endmodule
`default_nettype wire

//--- tb/acl_regs_tb.sv
`timescale 1ns/1ps
`default_nettype none
module acl_regs_tb;
  logic mclk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00;
  logic audio_mode = 1'b0, video_audio_sd = 1'b0, pin_audio_sd = 1'b0;
  logic tdm_conv_clk = 1'b0, base_audio_clk = 1'b0, rd_d = 1'b0;
  logic x = 1'b0; // Expected single-bit result
  logic [3:0] vld = 4'h0; // Trigger strobes: type, frame, video, regen
  logic [39:0] fv = 40'h0; // Shared field value for all triggers
  logic [9:0] st = 10'h0; // Status pin bundle
  logic [7:0] c, q[$];
  integer seed = 94, n_mismatch = 0, cmp_count = 0, cyc = 0, i, k, n;
  integer np = 0;
  wire type_vld = vld[3], aif_vld = vld[2], avi_vld = vld[1];
  wire acr_vld = vld[0];
  wire [3:0] audio_type = fv[3:0];
  wire [7:0] aif_sum = fv[7:0], avi_sum = fv[7:0];
  wire [39:0] acr_ncts = fv;
  wire downstream_link_ready = st[9], serial_tx_active = st[8];
  wire remote_rx_locked = st[7], link_mode_entered = st[6];
  wire [1:0] serial_port_mode = st[5:4];
  wire input_data_valid = st[3], input_pll_lock = st[2];
  wire no_input_clock = st[1], input_a = st[0];
  wire [7:0] reg_rdata_r;
  wire downstream_audio_sd_r, downstream_audio_clk, tdm_conv_en_r;
  wire serial_audio_out_en_r, serial_audio_sd_r, audio_fifo_rst_r;
  acl_regs u_dut (.*);
  always #5 mclk = ~mclk;
  // Compare and count
  task chk(input string s, input [7:0] g, input [7:0] e);
    cmp_count = cmp_count + 1;
    if (g !== e) begin
      n_mismatch = n_mismatch + 1;
      $display("[FAIL] %0s exp %h got %h", s, e, g);
    end
  endtask
  // Register write, one strobe then an idle edge
  task wr(input [7:0] a, input [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
    @(posedge mclk);
  endtask
  // Register read, expected byte noted for the monitor
  task rd(input [7:0] a, input [7:0] e);
    q.push_back(e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    @(posedge mclk);
  endtask
  // One trigger sample, then time for any pulse
  task smp(input integer t, input [39:0] v);
    fv <= v;
    vld[t] <= 1'b1;
    @(posedge mclk);
    vld[t] <= 1'b0;
    repeat (4) @(posedge mclk);
  endtask
  task results;
    $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // Read monitor, pulse counter and hang guard
  always @(posedge mclk) begin
    rd_d <= reg_rd;
    cyc = cyc + 1;
    if (audio_fifo_rst_r === 1'b1) begin
      np = np + 1;
    end
    if (cyc == 3000) begin
      n_mismatch = n_mismatch + 1;
      results;
    end
  end
  always @(negedge mclk) begin
    if (rd_d) begin
      chk("rdata", reg_rdata_r, q.pop_front());
    end
  end
  initial begin
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (3) @(posedge mclk);
    rd(8'h55, 8'h0c);
    wr(8'h55, 8'hff);
    wr(8'h5a, 8'hff);
    wr(8'h3c, 8'hff);
    rd(8'h55, 8'hcf);
    rd(8'h5a, 8'h00);
    rd(8'h3c, 8'h00);
    $display("test registers done");
    for (i = 0; i < 24; i = i + 1) begin
      st <= 10'($random(seed));
      repeat (4) @(posedge mclk);
      x = &st[8:6] & st[3];
      c = {st[9], x, x ? st[5:4] : 2'h0, st[3:0]};
      rd(8'h5a, c);
    end
    $display("test status done");
    for (i = 0; i < 16; i = i + 1) begin
      c = 8'($random(seed));
      {audio_mode, video_audio_sd, pin_audio_sd, tdm_conv_clk,
        base_audio_clk} <= 5'($random(seed));
      wr(8'h55, c);
      @(posedge mclk);
      #1;
      chk("tdm", tdm_conv_en_r, c[7]);
      x = c[7] ? tdm_conv_clk : base_audio_clk;
      chk("clk", downstream_audio_clk, x);
      chk("oen", serial_audio_out_en_r, c[6] & !audio_mode);
      x = c[6] & !audio_mode & video_audio_sd;
      chk("ssd", serial_audio_sd_r, x);
      x = audio_mode ? pin_audio_sd : video_audio_sd;
      chk("dsd", downstream_audio_sd_r, x);
      @(posedge mclk);
    end
    $display("test audio done");
    for (k = 0; k < 8; k = k + 1) begin
      wr(8'h55, k[0] ? 8'h01 << k[2:1] : 8'h00);
      smp(k / 2, {8'($random(seed)), $random(seed)});
      n = np;
      smp(k / 2, fv ^ 40'h1);
      smp(k / 2, fv);
      chk("fifo", np - n, k[0]);
    end
    $display("test fifo done");
    results;
  end
endmodule
bind acl_regs acl_regs_props u_chk (.*);
`default_nettype wire
